// *** common/pfp_defines.svh ***
`ifndef PFP_DEFINES_SVH
`define PFP_DEFINES_SVH
`define PFP_ADDR_W 11
`define PFP_DEPTH 2048
`define PFP_BLANK 8'hFF
`define PFP_ADDR_ZERO 11'h000
`define PFP_ADDR_ONE 11'h001
`define PFP_ADDR_TWO 11'h002
`define PFP_CLK_MHZ 10
`define PFP_WRITE_US 1200
`define PFP_WRITE_CYC (`PFP_WRITE_US * `PFP_CLK_MHZ)
`define PFP_ERASE_US 10000
`define PFP_ERASE_CYC (`PFP_ERASE_US * `PFP_CLK_MHZ)
`define PFP_CNT_W 17
// apb register offsets
`define PFP_REG_CTRL 12'h000
`define PFP_REG_STAT 12'h004
`define PFP_REG_ADDR 12'h008
`define PFP_REG_DATA 12'h00C
// mode code {a,b,c,d}
`define PFP_M_WRCODE 4'h7
`define PFP_M_RDCODE 4'h3
`define PFP_M_LOCK1 4'hF
`define PFP_M_LOCK2 4'hC
`define PFP_M_ERASE 4'h8
`define PFP_M_SIG 4'h0
`endif

// *** common/pfp_pkg.sv ***
package pfp_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_WRITE, ST_LOCK1, ST_LOCK2, ST_ERASE
  } pfp_state_t;
endpackage

// *** common/pfp_mem_if.sv ***
`timescale 1ns/1ps
`include "pfp_defines.svh"
interface pfp_mem_if;
  logic we;
  logic [`PFP_ADDR_W-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface

// *** rtl/pfp_mem.sv ***
`timescale 1ns/1ps
`include "pfp_defines.svh"
module pfp_mem (
  // clock
  input wire logic core_clk,
  // access
  pfp_mem_if.mem port
);
  // array leaves the factory blank
  logic [7:0] store [0:`PFP_DEPTH-1] = '{default: `PFP_BLANK};
  always @(posedge core_clk) begin
    if (port.we) begin
      store[port.addr] <= port.wdata;
    end
    port.rdata <= store[port.addr];
  end
endmodule

// *** rtl/pfp_sync.sv ***
`timescale 1ns/1ps
module pfp_sync (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // level
  input wire logic async_in,
  output logic sync_out
);
  logic meta_r;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

// *** rtl/pfp_top.sv ***
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`include "pfp_defines.svh"
module pfp_top (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // programming pins
  input wire logic rst_pin,
  input wire logic hv_pin,
  input wire logic step_clock_pin,
  input wire logic program_strobe,
  input wire logic mode_sel_a,
  input wire logic mode_sel_b,
  input wire logic mode_sel_c,
  input wire logic mode_sel_d,
  input wire logic [7:0] data_port_in,
  output logic [7:0] data_port_out,
  output logic [7:0] data_port_oe_n,
  output logic ready_busy_out,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  parameter logic [7:0] SIG_BYTE0 = 8'h5A; // arbitrary id value
  parameter logic [7:0] SIG_BYTE1 = 8'hA5; // arbitrary id value
  parameter logic [7:0] SIG_BYTE2 = 8'hFF;
  parameter int WRITE_CYC = `PFP_WRITE_CYC;
  parameter int ERASE_CYC = `PFP_ERASE_CYC;

  // synchronised pins
  logic rstS, hvS, stepS, strobeS, selA, selB, selC, selD;
  logic strobeOnS;
  logic [7:0] dataS;
  pfp_sync uRst (.core_clk(core_clk), .reset_n(reset_n),
    .async_in(rst_pin), .sync_out(rstS));
  pfp_sync uHv (.core_clk(core_clk), .reset_n(reset_n),
    .async_in(hv_pin), .sync_out(hvS));
  pfp_sync uStep (.core_clk(core_clk), .reset_n(reset_n),
    .async_in(step_clock_pin), .sync_out(stepS));
  // strobe synced active high so reset shows it idle, no false edge
  pfp_sync uStb (.core_clk(core_clk), .reset_n(reset_n),
    .async_in(~program_strobe), .sync_out(strobeOnS));
  assign strobeS = ~strobeOnS;
  pfp_sync uSa (.core_clk(core_clk), .reset_n(reset_n),
    .async_in(mode_sel_a), .sync_out(selA));
  pfp_sync uSb (.core_clk(core_clk), .reset_n(reset_n),
    .async_in(mode_sel_b), .sync_out(selB));
  pfp_sync uSc (.core_clk(core_clk), .reset_n(reset_n),
    .async_in(mode_sel_c), .sync_out(selC));
  pfp_sync uSd (.core_clk(core_clk), .reset_n(reset_n),
    .async_in(mode_sel_d), .sync_out(selD));
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : gData
      pfp_sync uD (.core_clk(core_clk), .reset_n(reset_n),
        .async_in(data_port_in[gi]), .sync_out(dataS[gi]));
    end
  endgenerate

  // edge history
  logic rstD_r, stepD_r, strobeD_r;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rstD_r <= 1'b0;
      stepD_r <= 1'b0;
      strobeD_r <= 1'b1;
    end else begin
      rstD_r <= rstS;
      stepD_r <= stepS;
      strobeD_r <= strobeS;
    end
  end
  wire rstRise = rstS & ~rstD_r;
  wire stepRise = stepS & ~stepD_r;
  wire strobeFall = ~strobeS & strobeD_r;
  wire strobeRise = strobeS & ~strobeD_r;

  wire [3:0] modeCode = {selA, selB, selC, selD};
  wire isRdCode = rstS & ~hvS & (modeCode == `PFP_M_RDCODE);
  wire isRdSig = rstS & ~hvS & (modeCode == `PFP_M_SIG);
  wire isWrCode = hvS & (modeCode == `PFP_M_WRCODE);
  wire isLock1 = hvS & (modeCode == `PFP_M_LOCK1);
  wire isLock2 = hvS & (modeCode == `PFP_M_LOCK2);
  wire isErase = hvS & (modeCode == `PFP_M_ERASE);

  // address counter
  logic [`PFP_ADDR_W-1:0] addr_r, addr_nxt;
  assign addr_nxt = rstRise ? `PFP_ADDR_ZERO :
                    stepRise ? addr_r + 1'b1 : addr_r;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_r <= `PFP_ADDR_ZERO;
    end else begin
      addr_r <= addr_nxt;
    end
  end

  // write engine
  pfp_pkg::pfp_state_t state_r, state_nxt;
  logic [`PFP_CNT_W+3:0] cnt_r, cnt_nxt;
  logic [7:0] wrData_r, wrData_nxt;
  logic [`PFP_ADDR_W-1:0] wrAddr_r, wrAddr_nxt;
  logic lock1_r, lock1_nxt, lock2_r, lock2_nxt;
  logic busy_r, busy_nxt;
  logic pending_r, pending_nxt;
  logic [`PFP_ADDR_W-1:0] eraseAddr_r, eraseAddr_nxt;
  logic eraseHeld_r, eraseHeld_nxt;
  logic [7:0] oldByte;
  logic swWrite;
  logic [7:0] swData;

  pfp_mem_if memBus ();
  pfp_mem uMem (.core_clk(core_clk), .port(memBus.mem));

  wire doneCnt = (cnt_r == '0);
  wire [`PFP_CNT_W+3:0] wrCycles = (`PFP_CNT_W+4)'(WRITE_CYC);
  wire [`PFP_CNT_W+3:0] erCycles = (`PFP_CNT_W+4)'(ERASE_CYC);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = doneCnt ? cnt_r : cnt_r - 1'b1;
    wrData_nxt = wrData_r;
    wrAddr_nxt = wrAddr_r;
    lock1_nxt = lock1_r;
    lock2_nxt = lock2_r;
    busy_nxt = busy_r;
    pending_nxt = pending_r;
    eraseAddr_nxt = eraseAddr_r;
    eraseHeld_nxt = eraseHeld_r;
    case (state_r)
      pfp_pkg::ST_IDLE: begin
        eraseHeld_nxt = 1'b0;
        if (strobeFall && isErase) begin
          state_nxt = pfp_pkg::ST_ERASE;
          cnt_nxt = erCycles;
          eraseAddr_nxt = `PFP_ADDR_ZERO;
        end else if (strobeFall && isWrCode && !lock1_r) begin
          state_nxt = pfp_pkg::ST_WRITE;
          cnt_nxt = wrCycles;
          wrData_nxt = dataS;
          wrAddr_nxt = addr_r;
          pending_nxt = 1'b1;
        end else if (strobeFall && isLock1) begin
          state_nxt = pfp_pkg::ST_LOCK1;
          cnt_nxt = wrCycles;
          pending_nxt = 1'b1;
        end else if (strobeFall && isLock2) begin
          state_nxt = pfp_pkg::ST_LOCK2;
          cnt_nxt = wrCycles;
          pending_nxt = 1'b1;
        end
      end
      pfp_pkg::ST_WRITE, pfp_pkg::ST_LOCK1, pfp_pkg::ST_LOCK2: begin
        if (pending_r && strobeRise) begin
          pending_nxt = 1'b0;
          busy_nxt = 1'b1;
        end
        if (doneCnt && !pending_r) begin
          state_nxt = pfp_pkg::ST_IDLE;
          busy_nxt = 1'b0;
          if (state_r == pfp_pkg::ST_LOCK1) begin
            lock1_nxt = 1'b1;
          end
          if (state_r == pfp_pkg::ST_LOCK2) begin
            lock2_nxt = 1'b1;
          end
        end
      end
      pfp_pkg::ST_ERASE: begin
        eraseAddr_nxt = eraseAddr_r + 1'b1;
        if (eraseAddr_r == `PFP_ADDR_W'(`PFP_DEPTH - 1)) begin
          eraseHeld_nxt = 1'b1;
        end
        if (strobeRise) begin
          state_nxt = pfp_pkg::ST_IDLE;
          if (doneCnt && eraseHeld_r) begin
            lock1_nxt = 1'b0;
            lock2_nxt = 1'b0;
          end
        end
      end
      default: state_nxt = pfp_pkg::ST_IDLE;
    endcase
  end

  // one byte written at write end; program can only clear bits
  wire wrCommit = (state_r == pfp_pkg::ST_WRITE) && doneCnt && !pending_r;
  wire eraseWr = (state_r == pfp_pkg::ST_ERASE) && !eraseHeld_r;
  assign oldByte = memBus.rdata;
  assign memBus.we = wrCommit | eraseWr | swWrite;
  assign memBus.addr = eraseWr ? eraseAddr_r :
                       wrCommit ? wrAddr_r : addr_r;
  assign memBus.wdata = eraseWr ? `PFP_BLANK :
                        wrCommit ? (oldByte & wrData_r) : swData;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= pfp_pkg::ST_IDLE;
      cnt_r <= '0;
      wrData_r <= 8'h00;
      wrAddr_r <= `PFP_ADDR_ZERO;
      lock1_r <= 1'b0;
      lock2_r <= 1'b0;
      busy_r <= 1'b0;
      pending_r <= 1'b0;
      eraseAddr_r <= `PFP_ADDR_ZERO;
      eraseHeld_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      wrData_r <= wrData_nxt;
      wrAddr_r <= wrAddr_nxt;
      lock1_r <= lock1_nxt;
      lock2_r <= lock2_nxt;
      busy_r <= busy_nxt;
      pending_r <= pending_nxt;
      eraseAddr_r <= eraseAddr_nxt;
      eraseHeld_r <= eraseHeld_nxt;
    end
  end

  // read path
  wire writing = (state_r == pfp_pkg::ST_WRITE);
  wire pollHit = writing && (addr_r == wrAddr_r);
  wire codeOk = !(lock1_r && lock2_r);
  logic [7:0] sigByte;
  assign sigByte = (addr_r == `PFP_ADDR_ZERO) ? SIG_BYTE0 :
                   (addr_r == `PFP_ADDR_ONE) ? SIG_BYTE1 :
                   (addr_r == `PFP_ADDR_TWO) ? SIG_BYTE2 : `PFP_BLANK;
  logic [7:0] outByte;
  assign outByte = isRdSig ? sigByte :
                   pollHit ? {~wrData_r[7], 7'h00} :
                   codeOk ? memBus.rdata : `PFP_BLANK;
  wire driveOut = isRdSig | (isRdCode & (codeOk | pollHit));

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      data_port_out <= 8'h00;
      data_port_oe_n <= 8'hFF;
      ready_busy_out <= 1'b1;
    end else begin
      data_port_out <= outByte;
      data_port_oe_n <= {8{~driveOut}};
      // ready follows busy by one register stage; the stored byte reaches the port a cycle after ready rises
      ready_busy_out <= ~busy_r;
    end
  end

  // apb slave: ctrl bit0 writes data byte at counter (test backdoor)
  wire apbAcc = psel & penable;
  wire hitCtrl = (paddr == `PFP_REG_CTRL);
  wire hitStat = (paddr == `PFP_REG_STAT);
  wire hitAddr = (paddr == `PFP_REG_ADDR);
  wire hitData = (paddr == `PFP_REG_DATA);
  wire hitAny = hitCtrl | hitStat | hitAddr | hitData;
  logic [7:0] swData_r;
  assign swData = swData_r;
  assign swWrite = apbAcc & pwrite & hitCtrl & pwdata[0] &
                   (state_r == pfp_pkg::ST_IDLE) & !lock1_r;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      swData_r <= 8'h00;
    end else if (apbAcc && pwrite && hitData) begin
      swData_r <= pwdata[7:0];
    end
  end
  logic [31:0] rdMux;
  assign rdMux = hitStat ? {29'h0, busy_r, rstS, hvS} :
                 hitAddr ? {21'h0, addr_r} :
                 hitData ? {24'h0, swData_r} : 32'h0;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      prdata <= rdMux;
      pslverr <= psel & ~penable & ~hitAny;
    end
  end
endmodule

// *** testbench/pfp_chk_monitor.sv ***
`timescale 1ns/1ps
`include "pfp_defines.svh"
module pfp_chk_monitor #(
  parameter int WRITE_CYC = 20
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // pins
  input wire logic hv_pin,
  input wire logic program_strobe,
  input wire logic mode_sel_a,
  input wire logic mode_sel_b,
  input wire logic mode_sel_c,
  input wire logic mode_sel_d,
  input wire logic [7:0] data_port_oe_n,
  input wire logic ready_busy_out,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic [3:0] modeCode;
  int busyCnt_r;
  assign modeCode = {mode_sel_a, mode_sel_b, mode_sel_c, mode_sel_d};
  // length of the current busy stretch
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) busyCnt_r <= 0;
    else busyCnt_r <= ready_busy_out ? 0 : busyCnt_r + 1;
  end
  busy_cause_a: assert property (
    $fell(ready_busy_out) && modeCode != `PFP_M_ERASE |-> program_strobe)
    else $error("busy began with strobe low");
  busy_hold_a: assert property (
    $fell(ready_busy_out) |-> !ready_busy_out [*6])
    else $error("busy too short");
  busy_bound_a: assert property (
    modeCode == `PFP_M_WRCODE && !ready_busy_out |-> busyCnt_r < WRITE_CYC)
    else $error("write ran too long");
  wr_float_a: assert property (
    (hv_pin && modeCode == `PFP_M_WRCODE) [*6]
    |-> data_port_oe_n == 8'hFF)
    else $error("port driven while writing");
  oe_whole_a: assert property (
    data_port_oe_n == 8'h00 || data_port_oe_n == 8'hFF)
    else $error("partial port drive");
  apb_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  apb_drop_a: assert property (!psel |=> !pready)
    else $error("ready without select");
  apb_err_a: assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule
bind pfp_top pfp_chk_monitor #(.WRITE_CYC(WRITE_CYC))
  pfp_chk_monitor_inst (.core_clk, .reset_n, .hv_pin, .program_strobe,
  .mode_sel_a, .mode_sel_b, .mode_sel_c, .mode_sel_d, .data_port_oe_n,
  .ready_busy_out, .psel, .penable, .pready, .pslverr);

// *** testbench/pfp_write_strobe_low_model.sv ***
`timescale 1ns/1ps
module pfp_write_strobe_low_model (
  // clock
  input wire logic core_clk,
  // to device
  output logic rstPin,
  output logic hvPin,
  output logic stepPin,
  output logic strobe,
  output logic [3:0] modeCode,
  output logic [7:0] dataIn,
  // from device
  input wire logic [7:0] dataOut,
  input wire logic [7:0] dataOeN,
  input wire logic readyBusy
);
  logic [7:0] progData;
  logic progOe;
  // bits released by both the device and the model show the inverse of the last value
  assign dataIn = (~dataOeN & dataOut) |
    (dataOeN & (progOe ? progData : ~progData));
  initial begin
    rstPin = 1'b0;
    stepPin = 1'b0;
    hvPin = 1'b0;
    strobe = 1'b1;
    modeCode = 4'h0;
    progData = 8'h00;
    progOe = 1'b0;
  end
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic mode(input logic [3:0] m, input logic hv);
    @(posedge core_clk);
    modeCode <= m;
    hvPin <= hv;
    progOe <= hv;
    idle(8);
  endtask
  task automatic clear_addr();
    @(posedge core_clk);
    rstPin <= 1'b0;
    idle(6);
    rstPin <= 1'b1;
    idle(8);
  endtask
  task automatic step();
    idle(10);
    stepPin <= 1'b1;
    idle(4);
    stepPin <= 1'b0;
    idle(4);
  endtask
  task automatic power_down();
    @(posedge core_clk);
    stepPin <= 1'b0;
    idle(4);
    rstPin <= 1'b0;
    idle(4);
  endtask
  task automatic pulse(input logic [7:0] d, input int w);
    @(posedge core_clk);
    progData <= d;
    idle(10);
    strobe <= 1'b0;
    idle(w);
    strobe <= 1'b1;
  endtask
  task automatic await_ready(output bit ok);
    int n;
    n = 0;
    ok = 1'b0;
    idle(8);
    while (n < 4000 && !ok) begin
      @(posedge core_clk);
      ok = (readyBusy === 1'b1);
      n++;
    end
  endtask
endmodule

// *** testbench/pfp_top_tb.sv ***
`timescale 1ns/1ps
`include "pfp_defines.svh"
module pfp_top_tb;
  localparam int WR_CYC = 20;
  localparam int ER_CYC = 3000;
  localparam logic [7:0] SIG0 = 8'h3E;
  localparam logic [7:0] SIG1 = 8'hC1;
  localparam logic [7:0] SIG2 = 8'h77;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic rstPin, hvPin, stepPin, strobe, readyBusy;
  logic [3:0] modeCode;
  logic [7:0] dataIn, dataOut, dataOeN;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  int err_count = 0;
  int checks_done = 0;
  always #50 core_clk = ~core_clk;
  pfp_top #(.WRITE_CYC(WR_CYC), .ERASE_CYC(ER_CYC), .SIG_BYTE0(SIG0),
    .SIG_BYTE1(SIG1), .SIG_BYTE2(SIG2)) pfp_top_inst (
    .core_clk, .reset_n, .rst_pin(rstPin), .hv_pin(hvPin),
    .step_clock_pin(stepPin), .program_strobe(strobe),
    .mode_sel_a(modeCode[3]), .mode_sel_b(modeCode[2]),
    .mode_sel_c(modeCode[1]), .mode_sel_d(modeCode[0]),
    .data_port_in(dataIn), .data_port_out(dataOut),
    .data_port_oe_n(dataOeN), .ready_busy_out(readyBusy), .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
  pfp_write_strobe_low_model pfp_write_strobe_low_model_inst (.core_clk, .rstPin, .hvPin,
    .stepPin, .strobe, .modeCode, .dataIn, .dataOut, .dataOeN,
    .readyBusy);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] exp);
    @(negedge core_clk);
    chk({16'h0, dataOeN, dataOut}, {24'h0, exp});
  endtask
  task automatic wr(input logic [3:0] m, input logic [7:0] d, input int w);
    bit ok;
    pfp_write_strobe_low_model_inst.mode(m, 1'b1);
    pfp_write_strobe_low_model_inst.pulse(d, w);
    pfp_write_strobe_low_model_inst.await_ready(ok);
    chk({31'h0, ok}, 32'h1);
    pfp_write_strobe_low_model_inst.mode(`PFP_M_RDCODE, 1'b0);
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    output logic [31:0] d, output logic e);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= 32'h0000_00A5;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_write();
    bit ok;
    pfp_write_strobe_low_model_inst.clear_addr();
    pfp_write_strobe_low_model_inst.mode(`PFP_M_RDCODE, 1'b0);
    rd(8'hFF);
    pfp_write_strobe_low_model_inst.mode(`PFP_M_WRCODE, 1'b1);
    pfp_write_strobe_low_model_inst.pulse(8'hA5, 2);
    pfp_write_strobe_low_model_inst.mode(`PFP_M_RDCODE, 1'b0);
    rd(8'h00);
    chk({31'h0, readyBusy}, 32'h0);
    pfp_write_strobe_low_model_inst.await_ready(ok);
    chk({31'h0, ok}, 32'h1);
    rd(8'hA5);
    wr(`PFP_M_WRCODE, 8'h0F, 2);
    rd(8'h05);
    pfp_write_strobe_low_model_inst.step();
    wr(`PFP_M_WRCODE, 8'h3C, 2);
    rd(8'h3C);
    pfp_write_strobe_low_model_inst.clear_addr();
    rd(8'h05);
    pfp_write_strobe_low_model_inst.mode(`PFP_M_WRCODE, 1'b0);
    pfp_write_strobe_low_model_inst.pulse(8'h00, 2);
    pfp_write_strobe_low_model_inst.idle(8);
    chk({31'h0, readyBusy}, 32'h1);
    pfp_write_strobe_low_model_inst.mode(`PFP_M_RDCODE, 1'b0);
    rd(8'h05);
    $display("write test done");
  endtask
  task automatic t_sig();
    logic [7:0] sig [3];
    sig = '{SIG0, SIG1, SIG2};
    pfp_write_strobe_low_model_inst.mode(`PFP_M_SIG, 1'b0);
    pfp_write_strobe_low_model_inst.clear_addr();
    for (int i = 0; i < 3; i++) begin
      rd(sig[i]);
      pfp_write_strobe_low_model_inst.step();
    end
    $display("signature test done");
  endtask
  task automatic t_lock();
    wr(`PFP_M_LOCK1, 8'h00, 2);
    pfp_write_strobe_low_model_inst.clear_addr();
    pfp_write_strobe_low_model_inst.step();
    pfp_write_strobe_low_model_inst.step();
    wr(`PFP_M_WRCODE, 8'h00, 2);
    rd(8'hFF);
    wr(`PFP_M_LOCK2, 8'h00, 2);
    @(posedge core_clk);
    chk({24'h0, dataOeN}, 32'hFF);
    wr(`PFP_M_ERASE, 8'h00, ER_CYC + 10);
    pfp_write_strobe_low_model_inst.clear_addr();
    rd(8'hFF);
    wr(`PFP_M_WRCODE, 8'h3C, 2);
    rd(8'h3C);
    $display("lock and erase test done");
  endtask
  task automatic t_apb();
    logic [31:0] d;
    logic e;
    apb(1'b1, 12'h010, d, e);
    chk({31'h0, e}, 32'h1);
    apb(1'b0, `PFP_REG_STAT, d, e);
    chk({31'h0, e}, 32'h0);
    chk(d, 32'h0000_0002);
    apb(1'b1, `PFP_REG_DATA, d, e);
    apb(1'b0, `PFP_REG_DATA, d, e);
    chk(d, 32'h0000_00A5);
    apb(1'b1, `PFP_REG_CTRL, d, e);
    pfp_write_strobe_low_model_inst.idle(4);
    rd(8'hA5);
    $display("apb test done");
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge core_clk);
    err_count++;
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    t_write();
    t_sig();
    t_lock();
    t_apb();
    pfp_write_strobe_low_model_inst.power_down();
    print_verdict();
  end
endmodule
